// ===== adpdc_pkg.sv
`default_nettype none
package adpdc_pkg;
    // Register offsets
    localparam logic [9:0] ADPDC_PATH_OFS = 10'h102;
    localparam logic [9:0] ADPDC_RATE_OFS = 10'h140;
    localparam logic [9:0] ADPDC_HP_OFS = 10'h141;
    localparam logic [9:0] ADPDC_ACQ_OFS = 10'h143;
    localparam logic [9:0] ADPDC_ROUND_OFS = 10'h144;
    // Reset values
    localparam logic [15:0] ADPDC_PATH_RST = 16'h2222;
    localparam logic [15:0] ADPDC_RATE_RST = 16'h0003;
    localparam logic [15:0] ADPDC_HP_RST = 16'h0018;
    localparam logic [15:0] ADPDC_ACQ_RST = 16'h0000;
    localparam logic [15:0] ADPDC_ROUND_RST = 16'h0002;
    // Implemented bits, reserved bits read as zero
    localparam logic [15:0] ADPDC_PATH_MASK = 16'h7777;
    localparam logic [15:0] ADPDC_RATE_MASK = 16'h0007;
    localparam logic [15:0] ADPDC_HP_MASK = 16'h007F;
    localparam logic [15:0] ADPDC_ACQ_MASK = 16'h003F;
    localparam logic [15:0] ADPDC_ROUND_MASK = 16'h0003;
    // Field positions
    localparam int ADPDC_PATH_STRIDE = 4;
    localparam int ADPDC_HP_ON_BIT = 0;
    localparam int ADPDC_HIGHPASS_SHIFT_VALUE_LSB = 1;
    localparam int ADPDC_EQ4_BIT = 6;
    localparam int ADPDC_ACQ_MODE_BIT = 0;
    localparam int ADPDC_ACQ_RATE_LSB = 1;
    localparam int ADPDC_ACQ_CYC_LSB = 4;
    // Field codes
    localparam logic [2:0] ADPDC_SRC_OFF = 3'h0;
    localparam logic [2:0] ADPDC_SRC_FULL = 3'h1;
    localparam logic [2:0] ADPDC_SRC_NO_EQ = 3'h2;
    localparam logic [2:0] ADPDC_SRC_BYPASS = 3'h3;
    localparam logic [2:0] ADPDC_SRC_SWAP = 3'h4;
    localparam logic [2:0] ADPDC_SRC_TEST = 3'h5;
    localparam logic [4:0] ADPDC_HIGHPASS_SHIFT_VALUE_DC = 5'h00;
    localparam logic [1:0] ADPDC_CYC_CODE_16 = 2'h0;
    localparam logic [1:0] ADPDC_CYC_CODE_24 = 2'h1;
    localparam logic [1:0] ADPDC_CYC_CODE_32 = 2'h2;
    localparam logic [5:0] ADPDC_CYC_16 = 6'h10;
    localparam logic [5:0] ADPDC_CYC_24 = 6'h18;
    localparam logic [5:0] ADPDC_CYC_32 = 6'h20;
    // Datapath steering for one converter channel
    typedef struct packed {
        logic enable;
        logic amp_on;
        logic eq_on;
        logic swap;
        logic test_pin;
    } adpdc_path_t;
    // Decimator and filter steering shared by all channels
    typedef struct packed {
        logic [2:0] rate;
        logic hp_on;
        logic [4:0] highpass_shift_value;
        logic dc_cal;
        logic eq4_on;
        logic acq_mode;
        logic [5:0] acq_cycles;
        logic [2:0] acq_rate;
        logic [1:0] rounding;
    } adpdc_filt_t;
endpackage
`default_nettype wire

// ===== adpdc_top.sv
`timescale 1ns/10ps
`default_nettype none
module adpdc_top import adpdc_pkg::*; (
    input wire logic CLK, // 100 MHz clock
    input wire logic RST_B, // Asynchronous reset, active low
    input wire logic REG_WR, // Write strobe, one cycle
    input wire logic REG_RD, // Read strobe, one cycle
    input wire logic [9:0] REG_ADDR, // Register address
    input wire logic [15:0] REG_WDATA, // Write data
    output logic [15:0] REG_RDATA, // Read data, held until next read
    output logic REG_RVALID, // Read data valid pulse
    output adpdc_path_t [3:0] PATH_CFG, // Per-channel path steering
    output adpdc_filt_t FILT_CFG // Decimator and filter steering
);
    logic [15:0] path_reg;
    logic [15:0] rate_reg;
    logic [15:0] hp_reg;
    logic [15:0] acq_reg;
    logic [15:0] round_reg;

    // Map a path code onto the switches of one channel
    function automatic adpdc_path_t path_decode(input logic [2:0] code);
        adpdc_path_t p;
        p = '0;
        p.enable = (code != ADPDC_SRC_OFF);
        p.amp_on = (code == ADPDC_SRC_FULL) || (code == ADPDC_SRC_NO_EQ);
        p.eq_on = (code == ADPDC_SRC_FULL);
        p.swap = (code == ADPDC_SRC_SWAP);
        p.test_pin = (code == ADPDC_SRC_TEST);
        return p;
    endfunction

    // Address decode
    wire hit_path = (REG_ADDR == ADPDC_PATH_OFS);
    wire hit_rate = (REG_ADDR == ADPDC_RATE_OFS);
    wire hit_hp = (REG_ADDR == ADPDC_HP_OFS);
    wire hit_acq = (REG_ADDR == ADPDC_ACQ_OFS);
    wire hit_round = (REG_ADDR == ADPDC_ROUND_OFS);
    wire hit_any = hit_path | hit_rate | hit_hp | hit_acq | hit_round;

    // Read selection, unmapped addresses read zero
    wire [15:0] next_rdata = hit_path ? path_reg :
                             hit_rate ? rate_reg :
                             hit_hp ? hp_reg :
                             hit_acq ? acq_reg :
                             hit_round ? round_reg : 16'h0000;

    // Steering decode from the stored fields
    adpdc_path_t [3:0] next_path_cfg;
    adpdc_filt_t next_filt_cfg;
    wire [1:0] cyc_code = acq_reg[ADPDC_ACQ_CYC_LSB +: 2];
    wire [4:0] highpass_shift_value = hp_reg[ADPDC_HIGHPASS_SHIFT_VALUE_LSB +: 5];

    for (genvar i = 0; i < 4; i++) begin : g_chan
        assign next_path_cfg[i] = path_decode(path_reg[ADPDC_PATH_STRIDE*i +: 3]);
    end

    assign next_filt_cfg.rate = rate_reg[2:0];
    assign next_filt_cfg.hp_on = hp_reg[ADPDC_HP_ON_BIT];
    assign next_filt_cfg.highpass_shift_value = highpass_shift_value;
    assign next_filt_cfg.dc_cal = (highpass_shift_value == ADPDC_HIGHPASS_SHIFT_VALUE_DC);
    assign next_filt_cfg.eq4_on = hp_reg[ADPDC_EQ4_BIT];
    assign next_filt_cfg.acq_mode = acq_reg[ADPDC_ACQ_MODE_BIT];
    // Reserved cycle code gives zero cycles
    assign next_filt_cfg.acq_cycles = (cyc_code == ADPDC_CYC_CODE_16) ? ADPDC_CYC_16 :
                                      (cyc_code == ADPDC_CYC_CODE_24) ? ADPDC_CYC_24 :
                                      (cyc_code == ADPDC_CYC_CODE_32) ? ADPDC_CYC_32 : 6'h00;
    assign next_filt_cfg.acq_rate = acq_reg[ADPDC_ACQ_RATE_LSB +: 3];
    assign next_filt_cfg.rounding = round_reg[1:0];

    // Register writes, reserved bits are dropped
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            path_reg <= ADPDC_PATH_RST;
            rate_reg <= ADPDC_RATE_RST;
            hp_reg <= ADPDC_HP_RST;
            acq_reg <= ADPDC_ACQ_RST;
            round_reg <= ADPDC_ROUND_RST;
        end else if (REG_WR) begin
            if (hit_path) path_reg <= REG_WDATA & ADPDC_PATH_MASK;
            if (hit_rate) rate_reg <= REG_WDATA & ADPDC_RATE_MASK;
            if (hit_hp) hp_reg <= REG_WDATA & ADPDC_HP_MASK;
            if (hit_acq) acq_reg <= REG_WDATA & ADPDC_ACQ_MASK;
            if (hit_round) round_reg <= REG_WDATA & ADPDC_ROUND_MASK;
        end
    end

    // Read port, data held between reads
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 16'h0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) REG_RDATA <= next_rdata;
        end
    end

    // Steering outputs, registered
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PATH_CFG <= {4{path_decode(ADPDC_SRC_NO_EQ)}};
            FILT_CFG <= '0;
        end else begin
            PATH_CFG <= next_path_cfg;
            FILT_CFG <= next_filt_cfg;
        end
    end

    // All checks run on the register clock and rest while reset is held
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // Write of one path code into channel 0
    sequence path_wr_s(logic [2:0] code);
        REG_WR && hit_path && (REG_WDATA[2:0] == code);
    endsequence

    // Register storage and channel decode
    path_store_a: assert property (REG_WR && hit_path |=> path_reg == $past(REG_WDATA & ADPDC_PATH_MASK))
        else $error("path register did not store masked write");
    chan_off_a: assert property (path_wr_s(ADPDC_SRC_OFF) |=> ##1 !PATH_CFG[0].enable)
        else $error("disabled channel still enabled");
    chan_full_a: assert property (path_wr_s(ADPDC_SRC_FULL) |=> ##1 PATH_CFG[0].eq_on && PATH_CFG[0].amp_on)
        else $error("full chain code not decoded");
    chan_test_a: assert property (path_wr_s(ADPDC_SRC_TEST) |=> ##1 PATH_CFG[0].test_pin && !PATH_CFG[0].amp_on)
        else $error("test pin code not decoded");
    chan_swap_a: assert property (path_wr_s(ADPDC_SRC_SWAP) |=> ##1 PATH_CFG[0].swap && !PATH_CFG[0].test_pin)
        else $error("swap code not decoded");
    rate_out_a: assert property (REG_WR && hit_rate |=> ##1 FILT_CFG.rate == $past(REG_WDATA[2:0], 2))
        else $error("decimator rate not forwarded");
    // Filter stage, direct compares skipped on the first edge after reset where it still shows zero
    hp_on_a: assert property ($past(RST_B) |-> FILT_CFG.hp_on == $past(hp_reg[ADPDC_HP_ON_BIT]))
        else $error("high-pass enable mismatch");
    dc_cal_a: assert property ($past(RST_B) |-> FILT_CFG.dc_cal == ($past(hp_reg[5:1]) == ADPDC_HIGHPASS_SHIFT_VALUE_DC))
        else $error("DC calibration decode wrong");
    eq4_on_a: assert property ($rose(hp_reg[ADPDC_EQ4_BIT]) |=> FILT_CFG.eq4_on)
        else $error("phase equalizer enable late");
    acq_mode_a: assert property ($past(RST_B) |-> FILT_CFG.acq_mode == $past(acq_reg[ADPDC_ACQ_MODE_BIT]))
        else $error("acquisition mode mismatch");
    acq_cyc_a: assert property (cyc_code == ADPDC_CYC_CODE_24 |=> FILT_CFG.acq_cycles == ADPDC_CYC_24)
        else $error("acquisition cycle count wrong");
    acq_rate_a: assert property ($past(RST_B) |-> FILT_CFG.acq_rate == $past(acq_reg[3:1]))
        else $error("acquisition output rate mismatch");
    round_out_a: assert property ($past(RST_B) |-> FILT_CFG.rounding == $past(round_reg[1:0]))
        else $error("rounding method mismatch");
    chan_indep_a: assert property (path_wr_s(ADPDC_SRC_OFF) |=> ##1
        PATH_CFG[1].enable == ($past(path_reg[6:4]) != ADPDC_SRC_OFF))
        else $error("other channel disturbed by a disable");
    // Read answer one cycle after the strobe
    read_back_a: assert property (REG_RD |=> REG_RVALID && REG_RDATA == $past(next_rdata))
        else $error("read data not returned next cycle");

    // Remaining path codes on channel 0
    chan_noeq_a: assert property (path_wr_s(ADPDC_SRC_NO_EQ) |=> ##1
        PATH_CFG[0].enable && PATH_CFG[0].amp_on && !PATH_CFG[0].eq_on)
        else $error("equalizer skip code not decoded");
    chan_bypass_a: assert property (path_wr_s(ADPDC_SRC_BYPASS) |=> ##1 PATH_CFG[0].enable &&
        !PATH_CFG[0].amp_on && !PATH_CFG[0].eq_on && !PATH_CFG[0].swap && !PATH_CFG[0].test_pin)
        else $error("bypass code not decoded");

    // Switch consistency on every channel
    for (genvar j = 0; j < 4; j++) begin : g_chan_chk
        chan_route_a: assert property ($onehot0({PATH_CFG[j].amp_on, PATH_CFG[j].swap, PATH_CFG[j].test_pin}))
            else $error("conflicting path switches on a channel");
        chan_chain_a: assert property (PATH_CFG[j].eq_on |-> PATH_CFG[j].amp_on)
            else $error("equalizer on without amplifier chain");
        chan_enable_a: assert property (PATH_CFG[j].amp_on || PATH_CFG[j].swap || PATH_CFG[j].test_pin |->
            PATH_CFG[j].enable)
            else $error("routed channel not enabled");
        chan_quiet_a: assert property (!PATH_CFG[j].enable |->
            !PATH_CFG[j].amp_on && !PATH_CFG[j].eq_on && !PATH_CFG[j].swap && !PATH_CFG[j].test_pin)
            else $error("disabled channel still routed");
    end

    // Filter and acquisition fields one stage behind the registers
    highpass_shift_value_a: assert property ($past(RST_B) |-> FILT_CFG.highpass_shift_value == $past(highpass_shift_value))
        else $error("high-pass shift mismatch");
    eq4_off_a: assert property ($fell(hp_reg[ADPDC_EQ4_BIT]) |=> !FILT_CFG.eq4_on)
        else $error("phase equalizer disable late");
    acq_cyc16_a: assert property (cyc_code == ADPDC_CYC_CODE_16 |=> FILT_CFG.acq_cycles == ADPDC_CYC_16)
        else $error("16-cycle acquisition count wrong");
    acq_cyc32_a: assert property (cyc_code == ADPDC_CYC_CODE_32 |=> FILT_CFG.acq_cycles == ADPDC_CYC_32)
        else $error("32-cycle acquisition count wrong");

    // Steering moves only when the stored words move
    path_steady_a: assert property ($stable(path_reg) |=> $stable(PATH_CFG))
        else $error("path steering moved without a register change");
    filt_steady_a: assert property ($past(RST_B) && $stable(rate_reg) && $stable(hp_reg) &&
        $stable(acq_reg) && $stable(round_reg) |=> $stable(FILT_CFG))
        else $error("filter steering moved without a register change");

    // Stored words change only on a write to their own offset
    path_hold_a: assert property (!(REG_WR && hit_path) |=> $stable(path_reg))
        else $error("path register changed without a write");
    rate_hold_a: assert property (!(REG_WR && hit_rate) |=> $stable(rate_reg))
        else $error("rate register changed without a write");
    hp_hold_a: assert property (!(REG_WR && hit_hp) |=> $stable(hp_reg))
        else $error("high-pass register changed without a write");
    acq_hold_a: assert property (!(REG_WR && hit_acq) |=> $stable(acq_reg))
        else $error("acquisition register changed without a write");
    round_hold_a: assert property (!(REG_WR && hit_round) |=> $stable(round_reg))
        else $error("rounding register changed without a write");
    rsvd_zero_a: assert property (((path_reg & ~ADPDC_PATH_MASK) | (rate_reg & ~ADPDC_RATE_MASK) |
        (hp_reg & ~ADPDC_HP_MASK) | (acq_reg & ~ADPDC_ACQ_MASK) | (round_reg & ~ADPDC_ROUND_MASK)) == 16'h0000)
        else $error("reserved bits stored");

    // Read port timing and unmapped offsets
    rvalid_pulse_a: assert property (!REG_RD |=> !REG_RVALID)
        else $error("read valid without a read strobe");
    rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed between reads");
    unmapped_rd_a: assert property (REG_RD && !hit_any |=> REG_RDATA == 16'h0000)
        else $error("unmapped offset read nonzero");

    // A path write followed by a read of the path word returns it
    sequence path_wr_any_s;
        REG_WR && hit_path;
    endsequence
    sequence path_rd_later_s;
        path_wr_any_s ##1 !(REG_WR && hit_path) ##1 (REG_RD && hit_path);
    endsequence
    path_readback_a: assert property (path_rd_later_s |=> REG_RDATA == $past(REG_WDATA & ADPDC_PATH_MASK, 3))
        else $error("path word not read back");
endmodule
`default_nettype wire

// ===== adpdc_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adpdc_bench import adpdc_pkg::*; ;
    localparam logic [9:0] OFS [5] = '{ADPDC_PATH_OFS, ADPDC_RATE_OFS, ADPDC_HP_OFS, ADPDC_ACQ_OFS, ADPDC_ROUND_OFS};
    localparam logic [15:0] RSTV [5] = '{ADPDC_PATH_RST, ADPDC_RATE_RST, ADPDC_HP_RST, ADPDC_ACQ_RST, ADPDC_ROUND_RST};
    localparam logic [15:0] MSK [5] = '{ADPDC_PATH_MASK, ADPDC_RATE_MASK, ADPDC_HP_MASK, ADPDC_ACQ_MASK, ADPDC_ROUND_MASK};
    logic clk, rst_b, reg_wr, reg_rd, reg_rvalid;
    logic [9:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    adpdc_path_t [3:0] path_cfg;
    adpdc_filt_t filt_cfg;
    logic [15:0] shadow [5];
    int fails, tests_run, seed, k;
    adpdc_top u_adpdc_top (.CLK(clk), .RST_B(rst_b), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .PATH_CFG(path_cfg), .FILT_CFG(filt_cfg));
    // Expected steering of one channel from its path code
    function automatic adpdc_path_t path_exp(input logic [2:0] c);
        path_exp = '{c != 3'h0, c == 3'h1 || c == 3'h2, c == 3'h1, c == 3'h4, c == 3'h5};
    endfunction
    // Expected shared filter steering from the shadow registers
    function automatic adpdc_filt_t filt_exp();
        filt_exp.rate = shadow[1][2:0];
        filt_exp.hp_on = shadow[2][0];
        filt_exp.highpass_shift_value = shadow[2][5:1];
        filt_exp.dc_cal = shadow[2][5:1] == ADPDC_HIGHPASS_SHIFT_VALUE_DC;
        filt_exp.eq4_on = shadow[2][6];
        filt_exp.acq_mode = shadow[3][0];
        filt_exp.acq_cycles = shadow[3][5:4] == ADPDC_CYC_CODE_16 ? ADPDC_CYC_16 :
            shadow[3][5:4] == ADPDC_CYC_CODE_24 ? ADPDC_CYC_24 : shadow[3][5:4] == ADPDC_CYC_CODE_32 ? ADPDC_CYC_32 : 6'h00;
        filt_exp.acq_rate = shadow[3][3:1];
        filt_exp.rounding = shadow[4][1:0];
    endfunction
    // Verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Compare a register word
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Compare a steering output
    task automatic chk_cfg(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One write strobe, driven on the falling edge
    task automatic wr(input logic [9:0] a, input logic [15:0] v);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // One read strobe, answer looked at in the cycle after the taking edge
    task automatic rd_chk(input logic [9:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk_word("read valid", 16'h0001, {15'h0000, reg_rvalid});
        chk_word("read data", e, reg_rdata);
        @(negedge clk);
        chk_word("read valid end", 16'h0000, {15'h0000, reg_rvalid});
        chk_word("read data held", e, reg_rdata);
    endtask
    // Steering outputs one edge after the register update
    task automatic check_cfg();
        @(negedge clk);
        for (int ch = 0; ch < 4; ch++) begin
            chk_cfg("path steering", {27'h0000000, path_exp(shadow[0][4*ch+:3])}, {27'h0000000, path_cfg[ch]});
        end
        chk_cfg("filter steering", {9'h000, filt_exp()}, {9'h000, filt_cfg});
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog against a hung run
    initial begin
        #200000;
        fails++;
        results();
    end
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 10'h000;
        reg_wdata = 16'h0000;
        seed = 32'h4CA41B8F;
        fails = 0;
        tests_run = 0;
        for (int i = 0; i < 5; i++) shadow[i] = RSTV[i];
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(OFS[i], RSTV[i]);
        rd_chk(10'h142, 16'h0000);
        check_cfg();
        // Every path code on every channel, reserved bits set
        for (int c = 0; c < 6; c++) begin
            d = 16'h0000;
            for (int ch = 0; ch < 4; ch++) d[4*ch+:3] = 3'((c + ch) % 6);
            wr(OFS[0], d | 16'h8888);
            shadow[0] = d;
            check_cfg();
            rd_chk(OFS[0], d);
        end
        // DC calibration with filter and equalizer on
        wr(OFS[2], 16'h0041);
        shadow[2] = 16'h0041;
        check_cfg();
        // Write and read together see the old contents
        @(negedge clk);
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        reg_addr = OFS[4];
        reg_wdata = 16'h0001;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        chk_word("old data", shadow[4], reg_rdata);
        shadow[4] = 16'h0001;
        check_cfg();
        // Random legal traffic, unmapped address included
        for (int n = 0; n < 60; n++) begin
            k = $unsigned($random(seed)) % 6;
            d = 16'($random(seed));
            if (k == 0) for (int ch = 0; ch < 4; ch++) d[4*ch+:3] = d[4*ch+:3] % 3'h6;
            if (k == 1) d[2:0] = 3'h2 + d[2:0] % 3'h6;
            if (k == 3 && d[5:4] == 2'h3) d[5:4] = 2'h2;
            if (k == 4 && d[1:0] == 2'h3) d[1:0] = 2'h0;
            wr(k == 5 ? 10'h3FF : OFS[k], d);
            if (k < 5) shadow[k] = d & MSK[k];
            rd_chk(k == 5 ? 10'h3FF : OFS[k], k == 5 ? 16'h0000 : shadow[k]);
            check_cfg();
        end
        // Reset in mid-run: read port and steering return to their reset state
        @(negedge clk);
        rst_b = 1'b0;
        for (int i = 0; i < 5; i++) shadow[i] = RSTV[i];
        @(negedge clk);
        chk_word("reset read data", 16'h0000, reg_rdata);
        chk_word("reset read valid", 16'h0000, {15'h0000, reg_rvalid});
        for (int ch = 0; ch < 4; ch++) begin
            chk_cfg("reset path steering", {27'h0000000, path_exp(ADPDC_SRC_NO_EQ)}, {27'h0000000, path_cfg[ch]});
        end
        chk_cfg("reset filter steering", 32'h00000000, {9'h000, filt_cfg});
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(OFS[i], RSTV[i]);
        check_cfg();
        results();
    end
endmodule
`default_nettype wire
